//--- src/vhp_pkg.sv
package vhp_pkg;
    localparam int MUXED_W = 8;

    // pin synchroniser vector layout
    localparam int SYNC_W      = 16;
    localparam int PIN_ALE     = 0;
    localparam int PIN_WR_N    = 1;
    localparam int PIN_RD_N    = 2;
    localparam int PIN_CS_N    = 3;
    localparam int PIN_MASTER  = 4;
    localparam int PIN_VBLANK  = 5;
    localparam int PIN_HBLANK  = 6;
    localparam int PIN_PEER    = 7;
    localparam int PIN_BUS_LSB = 8;

    // internal element addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00_A0;
    localparam logic [7:0] ADDR_STATUS = 8'h00_A1;
    localparam logic [7:0] ADDR_VCOUNT = 8'h00_A2;
    localparam logic [7:0] ADDR_HCOUNT = 8'h00_A3;

    // control element fields
    localparam int CTRL_GRID_BRIGHT = 0;
    localparam int CTRL_IRQ_EN      = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00_02;

    // status element fields
    localparam int STAT_VBL_START = 0;
    localparam int STAT_OVL_OWN   = 1;
    localparam int STAT_OVL_PEER  = 2;
    localparam logic [7:0] STATUS_RESET = 8'h00_00;

    // timing
    localparam longint CLK_HZ = 25_000_000;
    localparam longint DOT_HZ = 3_540_000;
    localparam int DOT_DIV = int'(CLK_HZ / DOT_HZ);
    localparam int H_TOTAL_DEF    = 228;
    localparam int H_ACTIVE_DEF   = 180;
    localparam int V_TOTAL_DEF    = 312;
    localparam int V_ACTIVE_DEF   = 240;
    localparam int BURST_BEG_DEF  = 190;
    localparam int BURST_END_DEF  = 200;

    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b001,
        BUS_WRITE = 3'b010,
        BUS_READ  = 3'b100
    } vhp_bus_e;
endpackage

//--- src/vhp_raster_if.sv
`timescale 1ns/100ps
interface vhp_raster_if #(parameter int HW = 8, parameter int VW = 9);
    logic          hblank;
    logic          vblank;
    logic          burst;
    logic [HW-1:0] hcount;
    logic [VW-1:0] vcount;
    logic          resync_h;
    logic          resync_v;

    modport gen (output hblank, vblank, burst, hcount, vcount,
                 input  resync_h, resync_v);
    modport use_side (input  hblank, vblank, burst, hcount, vcount,
                      output resync_h, resync_v);
endinterface

//--- src/vhp_raster_timing.sv
`timescale 1ns/100ps
module vhp_raster_timing #(
    parameter int H_TOTAL   = vhp_pkg::H_TOTAL_DEF,
    parameter int H_ACTIVE  = vhp_pkg::H_ACTIVE_DEF,
    parameter int V_TOTAL   = vhp_pkg::V_TOTAL_DEF,
    parameter int V_ACTIVE  = vhp_pkg::V_ACTIVE_DEF,
    parameter int BURST_BEG = vhp_pkg::BURST_BEG_DEF,
    parameter int BURST_END = vhp_pkg::BURST_END_DEF,
    parameter int HW        = 8,
    parameter int VW        = 9
) (
    input  wire logic   clk_in,
    input  wire logic   rst_in,
    vhp_raster_if.gen   raster
);
    localparam int DW = $clog2(vhp_pkg::DOT_DIV + 1);

    if (H_ACTIVE >= H_TOTAL || V_ACTIVE >= V_TOTAL ||
        H_TOTAL > (1 << HW) || V_TOTAL > (1 << VW) ||
        BURST_BEG < H_ACTIVE || BURST_END > H_TOTAL ||
        BURST_BEG >= BURST_END) begin : g_bad
        $error("vhp_raster_timing: inconsistent raster parameters");
    end

    typedef struct packed {
        logic [DW-1:0] div;
        logic [HW-1:0] h;
        logic [VW-1:0] v;
    } vhp_rt_s;

    vhp_rt_s state_reg;
    vhp_rt_s state_next;

    always_comb begin
        state_next = state_reg;
        // dot rate is an enable, not a second clock
        if (state_reg.div == DW'(vhp_pkg::DOT_DIV - 1)) begin
            state_next.div = '0;
            if (state_reg.h == HW'(H_TOTAL - 1)) begin
                state_next.h = '0;
                if (state_reg.v == VW'(V_TOTAL - 1)) begin
                    state_next.v = '0;
                end else begin
                    state_next.v = state_reg.v + 1'b1;
                end
            end else begin
                state_next.h = state_reg.h + 1'b1;
            end
        end else begin
            state_next.div = state_reg.div + 1'b1;
        end
        // slave: line and frame start follow the master's blanking
        if (raster.resync_h) begin
            state_next.h   = HW'(H_ACTIVE);
            state_next.div = '0;
        end
        if (raster.resync_v) begin
            state_next.v = VW'(V_ACTIVE);
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign raster.hcount = state_reg.h;
    assign raster.vcount = state_reg.v;
    assign raster.hblank = state_reg.h >= HW'(H_ACTIVE);
    assign raster.vblank = state_reg.v >= VW'(V_ACTIVE);
    assign raster.burst  = state_reg.h >= HW'(BURST_BEG) &&
                           state_reg.h <  HW'(BURST_END);
endmodule

//--- src/vhp_host_port.sv
// Overview of operation
// - while the address strobe is high the shared bus carries an address.
// - a store strobe writes bus data to the control element when it was last addressed.
// - fetch and store strobes count only while chip select is low.
// - a fetch strobe drives the addressed control, status or counter onto the bus.
// - the interrupt goes low for service and releases on a status read.
// - as master, own blanking is used inside and driven out.
// - as slave, outside blanking sets the internal timing.
// - vertical blank covers the whole vertical retrace.
// - horizontal blank covers the whole horizontal retrace.
// - brightness is minor OR major OR grid, grid only when grid-bright.
// - the burst window output marks where the colour burst goes.
// - peer brightness is checked against ours and overlaps go to status.
// - bus data is ignored outside address and store strobes.
`timescale 1ns/100ps
module vhp_host_port #(
    parameter int H_TOTAL   = vhp_pkg::H_TOTAL_DEF,
    parameter int H_ACTIVE  = vhp_pkg::H_ACTIVE_DEF,
    parameter int V_TOTAL   = vhp_pkg::V_TOTAL_DEF,
    parameter int V_ACTIVE  = vhp_pkg::V_ACTIVE_DEF,
    parameter int BURST_BEG = vhp_pkg::BURST_BEG_DEF,
    parameter int BURST_END = vhp_pkg::BURST_END_DEF
) (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] muxed_bus_in,
    output logic      [7:0] muxed_bus_out,
    output logic            muxed_bus_oe_n_out,
    input  wire logic       ale_in,
    input  wire logic       wr_n_in,
    input  wire logic       rd_n_in,
    input  wire logic       cs_n_in,
    output logic            irq_n_out,
    input  wire logic       master_in,
    input  wire logic       vertical_blank_in,
    output logic            vertical_blank_out,
    output logic            vertical_blank_oe_n_out,
    input  wire logic       horizontal_blank_in,
    output logic            horizontal_blank_out,
    output logic            horizontal_blank_oe_n_out,
    output logic            colour_burst_window_out,
    output logic            brightness_out,
    input  wire logic       peer_brightness_in,
    input  wire logic       minor_pattern_in,
    input  wire logic       major_pattern_in,
    input  wire logic       grid_in
);
    localparam int HW = $clog2(H_TOTAL);
    localparam int VW = $clog2(V_TOTAL);
    localparam int SW = vhp_pkg::SYNC_W;
    localparam int BL = vhp_pkg::PIN_BUS_LSB;
    // store and fetch strobes and chip select idle high, so no false strobe after reset
    localparam logic [SW-1:0] PIN_IDLE = SW'((1 << vhp_pkg::PIN_WR_N) |
                                             (1 << vhp_pkg::PIN_RD_N) |
                                             (1 << vhp_pkg::PIN_CS_N));

    if (HW > vhp_pkg::MUXED_W + 1 || VW > vhp_pkg::MUXED_W + 1) begin : g_bad
        $error("vhp_host_port: raster counters too wide for readback");
    end

    typedef struct packed {
        logic [SW-1:0]     sync1;
        logic [SW-1:0]     sync2;
        logic [SW-1:0]     prev;
        vhp_pkg::vhp_bus_e bus;
        logic [7:0]        addr;
        logic [7:0]        ctrl;
        logic [7:0]        status;
        logic [7:0]        rdata;
        logic              bus_oe_n;
        logic              irq_n;
        logic              vb_out;
        logic              hb_out;
        logic              blank_oe_n;
        logic              lum;
        logic              burst;
        logic              vb_int_prev;
    } vhp_hp_s;

    vhp_hp_s state_reg;
    vhp_hp_s state_next;

    vhp_raster_if #(.HW(HW), .VW(VW)) raster ();

    vhp_raster_timing #(
        .H_TOTAL   (H_TOTAL),
        .H_ACTIVE  (H_ACTIVE),
        .V_TOTAL   (V_TOTAL),
        .V_ACTIVE  (V_ACTIVE),
        .BURST_BEG (BURST_BEG),
        .BURST_END (BURST_END),
        .HW        (HW),
        .VW        (VW)
    ) u_timing (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .raster (raster)
    );

    logic [SW-1:0] pins;
    logic [SW-1:0] s;
    logic [SW-1:0] p;
    logic [7:0]    bus_last;
    logic          is_master;
    logic          vb_int;
    logic          own_lum;
    logic [7:0]    events;
    logic [7:0]    rd_mux;

    assign pins = {muxed_bus_in, peer_brightness_in, horizontal_blank_in,
                   vertical_blank_in, master_in, cs_n_in, rd_n_in,
                   wr_n_in, ale_in};
    assign s        = state_reg.sync2;
    assign p        = state_reg.prev;
    assign bus_last = p[BL +: 8];
    assign is_master = s[vhp_pkg::PIN_MASTER];

    // slave restarts its counters at the master's blanking edges
    assign raster.resync_h = !is_master && s[vhp_pkg::PIN_HBLANK] &&
                             !p[vhp_pkg::PIN_HBLANK];
    assign raster.resync_v = !is_master && s[vhp_pkg::PIN_VBLANK] &&
                             !p[vhp_pkg::PIN_VBLANK];
    assign vb_int = is_master ? raster.vblank
                              : s[vhp_pkg::PIN_VBLANK];

    assign own_lum = minor_pattern_in || major_pattern_in ||
                     (grid_in &&
                      state_reg.ctrl[vhp_pkg::CTRL_GRID_BRIGHT]);

    always_comb begin
        unique case (state_reg.addr)
            vhp_pkg::ADDR_CTRL:   rd_mux = state_reg.ctrl;
            vhp_pkg::ADDR_STATUS: rd_mux = state_reg.status;
            vhp_pkg::ADDR_VCOUNT: rd_mux = 8'(raster.vcount);
            vhp_pkg::ADDR_HCOUNT: rd_mux = 8'(raster.hcount);
            default:              rd_mux = '0;
        endcase
    end

    always_comb begin
        events = '0;
        events[vhp_pkg::STAT_VBL_START] = vb_int && !state_reg.vb_int_prev;
        events[vhp_pkg::STAT_OVL_OWN]   = minor_pattern_in &&
                                          major_pattern_in;
        events[vhp_pkg::STAT_OVL_PEER]  = own_lum &&
                                  s[vhp_pkg::PIN_PEER];
    end

    always_comb begin
        state_next       = state_reg;
        state_next.sync1 = pins;
        state_next.sync2 = state_reg.sync1;
        state_next.prev  = state_reg.sync2;
        state_next.vb_int_prev = vb_int;

        // address taken from the last sample with the strobe still high
        if (!s[vhp_pkg::PIN_ALE] && p[vhp_pkg::PIN_ALE]) begin
            state_next.addr = bus_last;
        end

        unique case (state_reg.bus)
            vhp_pkg::BUS_IDLE: begin
                if (!s[vhp_pkg::PIN_CS_N]) begin
                    if (!s[vhp_pkg::PIN_RD_N]) begin
                        state_next.bus      = vhp_pkg::BUS_READ;
                        state_next.rdata    = rd_mux;
                        state_next.bus_oe_n = 1'b0;
                    end else if (!s[vhp_pkg::PIN_WR_N]) begin
                        state_next.bus = vhp_pkg::BUS_WRITE;
                    end
                end
            end
            vhp_pkg::BUS_WRITE: begin
                // zero data hold: commit the sample before the rising edge
                if (s[vhp_pkg::PIN_WR_N]) begin
                    state_next.bus = vhp_pkg::BUS_IDLE;
                    if (state_reg.addr == vhp_pkg::ADDR_CTRL) begin
                        state_next.ctrl = bus_last;
                    end
                end
            end
            vhp_pkg::BUS_READ: begin
                if (s[vhp_pkg::PIN_RD_N]) begin
                    state_next.bus      = vhp_pkg::BUS_IDLE;
                    state_next.bus_oe_n = 1'b1;
                end
            end
            default: begin
                state_next.bus      = vhp_pkg::BUS_IDLE;
                state_next.bus_oe_n = 1'b1;
            end
        endcase

        // only bits shown to the host are cleared; new events win
        state_next.status = state_reg.status | events;
        if (state_reg.bus == vhp_pkg::BUS_READ && s[vhp_pkg::PIN_RD_N] &&
            state_reg.addr == vhp_pkg::ADDR_STATUS) begin
            state_next.status = (state_reg.status & ~state_reg.rdata)
                                | events;
        end
        state_next.irq_n = !(|state_next.status &&
                    state_reg.ctrl[vhp_pkg::CTRL_IRQ_EN]);

        state_next.vb_out     = raster.vblank;
        state_next.hb_out     = raster.hblank;
        state_next.blank_oe_n = !is_master;
        state_next.lum        = own_lum;
        state_next.burst      = raster.burst;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg            <= '0;
            state_reg.sync1      <= PIN_IDLE;
            state_reg.sync2      <= PIN_IDLE;
            state_reg.prev       <= PIN_IDLE;
            state_reg.bus        <= vhp_pkg::BUS_IDLE;
            state_reg.ctrl       <= vhp_pkg::CTRL_RESET;
            state_reg.status     <= vhp_pkg::STATUS_RESET;
            state_reg.bus_oe_n   <= 1'b1;
            state_reg.irq_n      <= 1'b1;
            state_reg.blank_oe_n <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign muxed_bus_out             = state_reg.rdata;
    assign muxed_bus_oe_n_out        = state_reg.bus_oe_n;
    assign irq_n_out                 = state_reg.irq_n;
    assign vertical_blank_out        = state_reg.vb_out;
    assign vertical_blank_oe_n_out   = state_reg.blank_oe_n;
    assign horizontal_blank_out      = state_reg.hb_out;
    assign horizontal_blank_oe_n_out = state_reg.blank_oe_n;
    assign colour_burst_window_out   = state_reg.burst;
    assign brightness_out            = state_reg.lum;
endmodule

//--- verification/vhp_host_port_checker.sv
`timescale 1ns/100ps
module vhp_host_port_checker (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic muxed_bus_oe_n_out,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic cs_n_in,
    input wire logic irq_n_out,
    input wire logic master_in,
    input wire logic vertical_blank_oe_n_out,
    input wire logic horizontal_blank_oe_n_out,
    input wire logic brightness_out,
    input wire logic minor_pattern_in,
    input wire logic major_pattern_in,
    input wire logic grid_in
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // pins pass two sync flops, so four settled samples are demanded
    AST_READ_DRIVE: assert property (
        (!rd_n_in && !cs_n_in) [*4] |=> !muxed_bus_oe_n_out)
        else $error("bus not driven during a selected read");
    AST_READ_RELEASE: assert property (
        rd_n_in [*4] |=> muxed_bus_oe_n_out)
        else $error("bus driven without a fetch strobe");
    AST_CS_GATE: assert property (
        cs_n_in [*4] |=> muxed_bus_oe_n_out)
        else $error("bus driven while not selected");
    // a control write may mask the request, so strobes of both kinds exempt
    AST_IRQ_HOLD: assert property (
        (!irq_n_out && rd_n_in && wr_n_in) [*8] |=> !irq_n_out)
        else $error("interrupt released without a read");
    AST_BRIGHT_ON: assert property (
        (minor_pattern_in || major_pattern_in) |=> brightness_out)
        else $error("brightness low while a pattern is active");
    AST_BRIGHT_OFF: assert property (
        !(minor_pattern_in || major_pattern_in || grid_in)
        |=> !brightness_out)
        else $error("brightness high with no pattern");
    AST_MASTER_DRIVE: assert property (
        master_in [*4] |=>
        !(vertical_blank_oe_n_out || horizontal_blank_oe_n_out))
        else $error("master does not drive blanking");
    AST_SLAVE_RELEASE: assert property (
        !master_in [*4] |=>
        (vertical_blank_oe_n_out && horizontal_blank_oe_n_out))
        else $error("slave drives blanking");
    cover property ($fell(irq_n_out));
    cover property ($rose(irq_n_out));
    cover property ($fell(muxed_bus_oe_n_out));
endmodule
bind vhp_host_port vhp_host_port_checker u_chk (.*);

//--- verification/vhp_host_model.sv
`timescale 1ns/100ps
module vhp_host_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] dev_bus_in,
    input  wire logic       dev_oe_n_in,
    output logic      [7:0] bus_out,
    output logic            ale_out,
    output logic            wr_n_out,
    output logic            rd_n_out,
    output logic            cs_n_out
);
    logic [7:0] drv;
    logic       drv_en;
    logic [7:0] idle = 8'h00_5A;
    initial begin
        {drv, drv_en} = {8'h00_00, 1'b0};
        {ale_out, wr_n_out, rd_n_out, cs_n_out} = 4'b0111;
    end
    // released bus flips each cycle so a stale byte never reads back
    always @(posedge clk_in) idle <= ~idle;
    assign bus_out = !dev_oe_n_in ? dev_bus_in : (drv_en ? drv : idle);
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask
    task automatic access(input logic wr, input logic [7:0] addr,
                          input logic [7:0] wdata, input logic sel_n,
                          output logic [7:0] rdata);
        int k;
        k = 0;
        drv = addr;
        drv_en = 1'b1;
        ale_out = 1'b1;
        step(3);
        ale_out = 1'b0;
        step(3);
        drv = wdata;
        drv_en = wr;
        cs_n_out = sel_n;
        {wr_n_out, rd_n_out} = {!wr, wr};
        step(4);
        while (!wr && !sel_n && dev_oe_n_in && k < 8) begin
            step(1);
            k++;
        end
        rdata = dev_bus_in;
        {wr_n_out, rd_n_out} = 2'b11;
        step(3);
        {drv_en, cs_n_out} = 2'b01;
        step(3);
    endtask
endmodule

//--- verification/tb.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin \
    n_tests++; \
    if ((got) !== (ex)) begin \
        fails++; \
        $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
    end \
end
module tb;
    localparam int HT  = 20;
    localparam int HA  = 16;
    localparam int VT  = 10;
    localparam int VA  = 8;
    localparam int DIV = vhp_pkg::DOT_DIV;
    logic       clk_in, rst_in, master_in, peer_brightness_in, vb_drv;
    logic       minor_pattern_in, major_pattern_in, grid_in, hb_drv;
    logic       ale_in, wr_n_in, rd_n_in, cs_n_in, irq_n_out;
    logic [7:0] muxed_bus_in, muxed_bus_out, lfsr, rdata;
    logic       muxed_bus_oe_n_out, colour_burst_window_out;
    logic       vertical_blank_out, vertical_blank_oe_n_out;
    logic       horizontal_blank_out, horizontal_blank_oe_n_out;
    logic       brightness_out;
    logic [1:0] sel;
    int         fails, n_tests, hi, per, k;
    wire vertical_blank_in = vertical_blank_oe_n_out ? vb_drv
                                                     : vertical_blank_out;
    wire horizontal_blank_in = horizontal_blank_oe_n_out ? hb_drv
                                                         : horizontal_blank_out;
    wire mon = sel == 2'd0 ? horizontal_blank_out
             : sel == 2'd1 ? vertical_blank_out : colour_burst_window_out;
    vhp_host_port #(.H_TOTAL(HT), .H_ACTIVE(HA), .V_TOTAL(VT), .V_ACTIVE(VA),
                    .BURST_BEG(17), .BURST_END(19)) u_dut (.*);
    vhp_host_model u_host (.clk_in(clk_in), .dev_bus_in(muxed_bus_out),
        .dev_oe_n_in(muxed_bus_oe_n_out), .bus_out(muxed_bus_in),
        .ale_out(ale_in), .wr_n_out(wr_n_in), .rd_n_out(rd_n_in),
        .cs_n_out(cs_n_in));
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function automatic logic lum(input logic [2:0] p, input logic gb);
        return p[0] | p[1] | (p[2] & gb);
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask
    task automatic acc(input logic wr, input logic [7:0] a,
                       input logic [7:0] d, input logic sel_n);
        u_host.access(wr, a, d, sel_n, rdata);
    endtask
    task automatic wait_lvl(input logic v, output int n);
        n = 0;
        while (mon !== v && n < 4000) begin
            step(1);
            n++;
        end
    endtask
    task automatic pulse(input logic [1:0] s);
        sel = s;
        wait_lvl(1'b0, hi);
        wait_lvl(1'b1, hi);
        wait_lvl(1'b0, hi);
        wait_lvl(1'b1, per);
        per = per + hi;
    endtask
    task automatic bright_run(input logic gb);
        logic e;
        for (int i = 0; i < 48; i++) begin
            lfsr = lfsr_next(lfsr);
            {grid_in, major_pattern_in, minor_pattern_in} =
                i == 0 ? 3'b100 : lfsr[2:0];
            e = lum({grid_in, major_pattern_in, minor_pattern_in}, gb);
            step(1);
            `CHK("brightness", e, brightness_out)
        end
        {grid_in, major_pattern_in, minor_pattern_in} = 3'b000;
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    initial begin
        repeat (40000) @(posedge clk_in);
        fails++;
        complete_run();
    end
    initial begin
        {rst_in, master_in, vb_drv, hb_drv, peer_brightness_in} = 5'b11000;
        {grid_in, major_pattern_in, minor_pattern_in} = 3'b000;
        {sel, lfsr, fails, n_tests} = {2'd0, 8'h00_56, 32'd0, 32'd0};
        step(6);
        rst_in = 1'b0;
        step(1);
        `CHK("bus_oe_n", 1'b1, muxed_bus_oe_n_out)
        `CHK("irq_n", 1'b1, irq_n_out)
        pulse(2'd0);
        `CHK("hblank width", (HT - HA) * DIV, hi)
        `CHK("line length", HT * DIV, per)
        pulse(2'd1);
        `CHK("vblank width", (VT - VA) * HT * DIV, hi)
        `CHK("frame length", VT * HT * DIV, per)
        pulse(2'd2);
        `CHK("burst width", 2 * DIV, hi)
        `CHK("burst period", HT * DIV, per)
        $display("raster timing test done");
        acc(1'b1, vhp_pkg::ADDR_CTRL, 8'h00_02, 1'b0);
        bright_run(1'b0);
        acc(1'b1, vhp_pkg::ADDR_CTRL, 8'h00_03, 1'b0);
        acc(1'b1, vhp_pkg::ADDR_CTRL, 8'h00_02, 1'b1);
        bright_run(1'b1);
        $display("brightness test done");
        {major_pattern_in, minor_pattern_in, peer_brightness_in} = 3'b111;
        step(6);
        {major_pattern_in, minor_pattern_in, peer_brightness_in} = 3'b000;
        // reads just after a vertical blank start, so no new event hits the clear
        sel = 2'd1;
        wait_lvl(1'b0, k);
        wait_lvl(1'b1, k);
        acc(1'b0, vhp_pkg::ADDR_STATUS, 8'h00_00, 1'b1);
        `CHK("irq_n", 1'b0, irq_n_out)
        acc(1'b0, vhp_pkg::ADDR_STATUS, 8'h00_00, 1'b0);
        `CHK("status", 8'h00_07, rdata & 8'h00_07)
        `CHK("irq_n", 1'b1, irq_n_out)
        acc(1'b0, vhp_pkg::ADDR_STATUS, 8'h00_00, 1'b0);
        `CHK("status", 8'h00_00, rdata & 8'h00_06)
        acc(1'b0, 8'h00_55, 8'h00_00, 1'b0);
        `CHK("unmapped", 8'h00_00, rdata)
        $display("status test done");
        acc(1'b1, vhp_pkg::ADDR_CTRL, 8'h00_01, 1'b0);
        acc(1'b0, vhp_pkg::ADDR_STATUS, 8'h00_00, 1'b0);
        k = 0;
        for (int i = 0; i < 1500; i++) begin
            step(1);
            k += (irq_n_out !== 1'b1);
        end
        `CHK("masked irq cycles", 0, k)
        $display("interrupt mask test done");
        master_in = 1'b0;
        step(6);
        `CHK("vb_oe_n", 1'b1, vertical_blank_oe_n_out)
        `CHK("hb_oe_n", 1'b1, horizontal_blank_oe_n_out)
        repeat (3) begin
            {vb_drv, hb_drv} = 2'b11;
            step(6);
            `CHK("hblank", 1'b1, horizontal_blank_out)
            `CHK("vblank", 1'b1, vertical_blank_out)
            {vb_drv, hb_drv} = 2'b00;
            lfsr = lfsr_next(lfsr);
            step(20 + int'(lfsr[3:0]));
        end
        master_in = 1'b1;
        step(6);
        `CHK("vb_oe_n", 1'b0, vertical_blank_oe_n_out)
        `CHK("hb_oe_n", 1'b0, horizontal_blank_oe_n_out)
        $display("master slave test done");
        complete_run();
    end
endmodule
